// ===== mtwp_defines.vh
// Constants for the multiplexed temperature word port
`ifndef MTWP_DEFINES_VH
`define MTWP_DEFINES_VH
// ==========================================
// Word layout
`define MTWP_DATA_LSB      0
`define MTWP_DATA_MSB      11
`define MTWP_CHAN_LSB      12
`define MTWP_CHAN_MSB      14
`define MTWP_SIGN_BIT      15
// ==========================================
// Values
`define MTWP_FULL_SCALE    12'hfff
`define MTWP_ZERO_CODE     12'h000
`define MTWP_FIRST_CHAN    3'h0
`define MTWP_LAST_CHAN     3'h7
`define MTWP_WORD_RESET    16'h0000
`define MTWP_NUM_CHAN      8
`endif

// ===== mtwp_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mtwp_sync (
  input  wire clock,
  input  wire reset_n,
  input  wire pin_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ==========================================
  // Stage chain; first stage feeds only the second
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

// ===== mtwp_port.v
// Multiplexed temperature word port: eight channels through one 16-bit input word
//
// What this block does
// - Bits 14:12 carry the active channel code, 000 for the first channel up to 111 for the eighth.
// - The channel code advances by one on each host scan so one channel is offered per scan.
// - After the eighth channel the sequence wraps back to the first and repeats forever.
// - Bit 15 is a sign flag, set for a negative temperature and clear for a positive one.
// - Bits 11:0 hold an unsigned binary magnitude, bit 0 weighing 1 and bit 11 weighing 2048.
// - In millivolt or raw-count operation the input span maps linearly onto codes 0 to 4095.
// - One code step is about 12.2 uV on the 50 mV variant and 24.4 uV on the 100 mV variant.
// - In temperature operation the magnitude is delivered directly in degrees of the chosen scale.
// - An open or burnt-out thermocouple channel reports 4095.
// - With raw-count selected, conversion is bypassed and a 0 to 4095 span value is reported.
`timescale 1ns/1ps
`include "mtwp_defines.vh"
module mtwp_port #(
  parameter NUM_CHAN = `MTWP_NUM_CHAN
) (
  input  wire                     clock,
  input  wire                     reset_n,
  input  wire                     host_scan,
  input  wire                     raw_count_select,
  input  wire [NUM_CHAN*12-1:0]   conv_magnitude,
  input  wire [NUM_CHAN-1:0]      conv_negative,
  input  wire [NUM_CHAN*12-1:0]   raw_count,
  input  wire [NUM_CHAN-1:0]      burnout,
  output reg  [15:0]              channel_result_word_q,
  output reg                      word_update_q
);

  // ==========================================
  // Channel sequencer states, one-hot
  localparam [7:0] CH0    = 8'h01;
  localparam [7:0] CH1    = 8'h02;
  localparam [7:0] CH2    = 8'h04;
  localparam [7:0] CH3    = 8'h08;
  localparam [7:0] CH4    = 8'h10;
  localparam [7:0] CH5    = 8'h20;
  localparam [7:0] CH6    = 8'h40;
  localparam [7:0] CH7    = 8'h80;
  localparam       SLOTS  = `MTWP_NUM_CHAN;
  localparam       PINS   = 2;
  localparam       DATA_W = `MTWP_DATA_MSB - `MTWP_DATA_LSB + 1;

  // ==========================================
  // Signals
  wire [PINS-1:0]    pin_raw;
  wire [PINS-1:0]    pin_lvl;
  wire               scan_lvl;
  wire               raw_lvl;
  wire               scan_edge;
  wire [DATA_W-1:0]  src_mag  [0:SLOTS-1];
  wire               src_sign [0:SLOTS-1];
  reg                scan_prev_q;
  reg  [7:0]         chan_q;
  reg  [7:0]         chan_d;
  reg  [2:0]         code_d;
  reg  [DATA_W-1:0]  mag_d;
  reg                sign_d;
  reg  [15:0]        word_d;
  genvar             g;

  // ==========================================
  // Decoding helpers
  // Code of a one-hot channel state; an illegal state reads as the first channel
  function [2:0] chan_code;
    input [7:0] onehot;
    begin
      case (onehot)
        CH0: begin
          chan_code = 3'h0;
        end
        CH1: begin
          chan_code = 3'h1;
        end
        CH2: begin
          chan_code = 3'h2;
        end
        CH3: begin
          chan_code = 3'h3;
        end
        CH4: begin
          chan_code = 3'h4;
        end
        CH5: begin
          chan_code = 3'h5;
        end
        CH6: begin
          chan_code = 3'h6;
        end
        CH7: begin
          chan_code = 3'h7;
        end
        default: begin
          chan_code = 3'h0;
        end
      endcase
    end
  endfunction
  function [DATA_W-1:0] src_mag_f;
    input              burn;
    input              raw_sel;
    input [DATA_W-1:0] raw;
    input [DATA_W-1:0] conv;
    begin
      if (burn) begin
        src_mag_f = `MTWP_FULL_SCALE;
      end else if (raw_sel) begin
        // Front end already spans the input range linearly; step size is set by the variant
        src_mag_f = raw;
      end else begin
        src_mag_f = conv;
      end
    end
  endfunction
  function src_sign_f;
    input burn;
    input raw_sel;
    input neg;
    begin
      if (burn || raw_sel) begin
        // Open inputs and raw counts carry no sign
        src_sign_f = 1'b0;
      end else begin
        src_sign_f = neg;
      end
    end
  endfunction

  // ==========================================
  // Pin synchronisers for scan strobe and raw-count selection
  assign pin_raw = {raw_count_select, host_scan};
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin_sync
      mtwp_sync mtwp_sync_i (
        .clock   (clock),
        .reset_n (reset_n),
        .pin_in  (pin_raw[g]),
        .level_q (pin_lvl[g])
      );
    end
  endgenerate
  assign scan_lvl  = pin_lvl[0];
  assign raw_lvl   = pin_lvl[1];
  // Previous level resets to the idle low of the pin, so reset release gives no false scan
  assign scan_edge = scan_lvl & ~scan_prev_q;

  // ==========================================
  // Per-channel sources; slots beyond NUM_CHAN read like open inputs
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : chan_src
      if (g < NUM_CHAN) begin : used
        assign src_mag[g]  = src_mag_f(burnout[g], raw_lvl, raw_count[g*DATA_W +: DATA_W],
                                       conv_magnitude[g*DATA_W +: DATA_W]);
        assign src_sign[g] = src_sign_f(burnout[g], raw_lvl, conv_negative[g]);
      end else begin : spare
        assign src_mag[g]  = `MTWP_FULL_SCALE;
        assign src_sign[g] = 1'b0;
      end
    end
  endgenerate

  // ==========================================
  // Channel sequencer: one step per scan, wrapping after the eighth channel
  always @* begin
    case (chan_q)
      CH0: begin
        chan_d = CH1;
      end
      CH1: begin
        chan_d = CH2;
      end
      CH2: begin
        chan_d = CH3;
      end
      CH3: begin
        chan_d = CH4;
      end
      CH4: begin
        chan_d = CH5;
      end
      CH5: begin
        chan_d = CH6;
      end
      CH6: begin
        chan_d = CH7;
      end
      CH7: begin
        chan_d = CH0;
      end
      default: begin
        chan_d = CH0;
      end
    endcase
  end

  // ==========================================
  // Next word: all three fields come from the same channel
  always @* begin
    code_d = chan_code(chan_d);
    mag_d  = src_mag[code_d];
    sign_d = src_sign[code_d];
    word_d = `MTWP_WORD_RESET;
    word_d[`MTWP_SIGN_BIT]                = sign_d;
    word_d[`MTWP_CHAN_MSB:`MTWP_CHAN_LSB] = code_d;
    word_d[`MTWP_DATA_MSB:`MTWP_DATA_LSB] = mag_d;
  end

  // ==========================================
  // Word register: all fields load on one edge so no torn word is seen
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scan_prev_q           <= 1'b0;
      // Parked on the last channel so the first scan offers the first
      chan_q                <= CH7;
      channel_result_word_q <= `MTWP_WORD_RESET;
      word_update_q         <= 1'b0;
    end else begin
      scan_prev_q   <= scan_lvl;
      word_update_q <= scan_edge;
      if (scan_edge) begin
        chan_q                <= chan_d;
        channel_result_word_q <= word_d;
      end
    end
  end
endmodule

// ===== mtwp_checker.sv
// Assertions on the word port outputs
`timescale 1ns/1ps
module mtwp_chk (
  input wire        clock,
  input wire        reset_n,
  input wire        host_scan,
  input wire [7:0]  burnout,
  input wire [15:0] channel_result_word_q,
  input wire        word_update_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [15:0] w = channel_result_word_q;
  wire        u = word_update_q;
  reg  [2:0]  c_q;
  // Reset to 7 so the first update must carry channel 0
  always @(posedge clock or negedge reset_n)
    if (!reset_n) c_q <= 3'h7;
    else if (u) c_q <= c_q + 3'h1;
  code_next_a: assert property (u |-> w[14:12] == c_q + 3'h1) else $error("bad code");
  code_wrap_a: assert property (u && c_q == 3'h7 |-> w[14:12] == 3'h0) else $error("no wrap");
  word_hold_a: assert property (!u |-> $stable(w)) else $error("word moved");
  pulse_gap_a: assert property (u |=> !u [*5]) else $error("pulse long");
  scan_ans_a: assert property ($rose(host_scan) |-> ##[4:6] u) else $error("no answer");
  no_scan_a: assert property (!host_scan [*8] |-> !u) else $error("stray word");
  burn_mag_a: assert property ((burnout == 8'hff) [*8] ##0 u |-> &w[11:0]) else $error("burn mag");
  burn_sign_a: assert property ((burnout == 8'hff) [*8] ##0 u |-> !w[15]) else $error("burn sign");
  cover property (u && burnout == 8'hff);
  cover property (u && w[15]);
  cover property (u && w[14:12] == 3'h7);
endmodule
bind mtwp_port mtwp_chk mtwp_chk_i (.clock, .reset_n, .host_scan, .burnout, .channel_result_word_q, .word_update_q);

// ===== mtwp_host.sv
// Host model: scans the port and files each word by its channel code
`timescale 1ns/1ps
module mtwp_host (
  input  wire        clock,
  input  wire [15:0] channel_result_word_q,
  input  wire        word_update_q,
  output reg         host_scan = 1'b0
);
  reg  [12:0] store [0:7];
  wire [15:0] w = channel_result_word_q;
  // High 4 cycles; gap of 1 gives the tightest legal spacing
  task scan(input integer gap);
    begin
      @(negedge clock) host_scan = 1'b1;
      repeat (4) @(negedge clock);
      host_scan = 1'b0;
      repeat (gap) @(negedge clock);
    end
  endtask
  always @(posedge clock) if (word_update_q) store[w[14:12]] <= {w[15], w[11:8], w[7:0]};
endmodule

// ===== mtwp_port_tb.sv
// Bench: conversion, raw-count and burnout modes, eight scans each
`timescale 1ns/1ps
module mtwp_port_tb;
  reg         clock = 1'b0, reset_n = 1'b0, raw_count_select = 1'b0;
  reg  [95:0] conv_magnitude, raw_count;
  reg  [7:0]  conv_negative = 8'h5a, burnout = 8'h00;
  wire [15:0] channel_result_word_q;
  wire        word_update_q, host_scan;
  integer     m, k, n_mismatch = 0, compares = 0;
  reg  [12:0] want;
  always #2 clock = ~clock;
  mtwp_port mtwp_port_i (.clock, .reset_n, .host_scan, .raw_count_select, .conv_magnitude, .conv_negative,
    .raw_count, .burnout, .channel_result_word_q, .word_update_q);
  mtwp_host mtwp_host_i (.clock, .channel_result_word_q, .word_update_q, .host_scan);
  task check(input [12:0] seen, input [12:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) n_mismatch = n_mismatch + 1;
      if (seen !== want) $display("ERROR %0t got %h want %h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    begin
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    for (k = 0; k < 8; k = k + 1) begin
      conv_magnitude[12*k +: 12] = 12'h800 >> k;
      raw_count[12*k +: 12] = 12'hfff >> k;
    end
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    // Modes: conversion, raw count, all open, raw count with the low half open
    for (m = 0; m < 4; m = m + 1) begin
      raw_count_select = (m == 1 || m == 3);
      burnout = (m == 2) ? 8'hff : (m == 3) ? 8'h0f : 8'h00;
      repeat (10) @(negedge clock);
      for (k = 0; k < 8; k = k + 1) mtwp_host_i.scan(2 + 4 * k);
      repeat (8) @(negedge clock);
      check({10'h000, channel_result_word_q[14:12]}, 13'h0007);
      for (k = 0; k < 8; k = k + 1) begin
        if (burnout[k]) want = 13'h0fff;
        else if (raw_count_select) want = {1'b0, raw_count[12*k +: 12]};
        else want = {conv_negative[k], conv_magnitude[12*k +: 12]};
        check(mtwp_host_i.store[k], want);
      end
    end
    report_and_stop;
  end
endmodule
